// ---- logic/dihp_regs.svh ----
// Port numbers, field positions and counts of the disk host port
`ifndef DIHP_REGS_SVH
`define DIHP_REGS_SVH

// Processor I/O ports, low byte of the address
`define DIHP_PORT_CMD       8'hf8
`define DIHP_PORT_TRACK     8'hf9
`define DIHP_PORT_SECTOR    8'hfa
`define DIHP_PORT_DATA      8'hfb
`define DIHP_PORT_WAIT      8'hfc
`define DIHP_SW_DEFAULT     5'h1f
`define DIHP_DEV_HI         7
`define DIHP_DEV_LO         3
`define DIHP_FAR_IDX        2
`define DIHP_NO_PORT_DATA   8'hff
`define DIHP_UNMAPPED_DATA  8'h00

// Wait port answer: top bit tells which event ended the wait
`define DIHP_WAIT_BY_REQ    8'h80
`define DIHP_WAIT_BY_IRQ    8'h00

// Extended command latch: drive select field
`define DIHP_EXT_RESET      8'h00
`define DIHP_DRV_HI         5
`define DIHP_DRV_LO         4

// Sector command decode for head loading
`define DIHP_CMD_TYPE2      2'h2
`define DIHP_CMD_TYPE_HI    7
`define DIHP_CMD_TYPE_LO    6
`define DIHP_CMD_HLD_BIT    2
`define DIHP_HEAD_REVS      2'h2

// Boot overlay
`define DIHP_PROM_WORDS     16'h0020
`define DIHP_PROM_AW        5

// Host software registers (index on the software port)
`define DIHP_SW_ORDER       4'h0
`define DIHP_SW_ADDR        4'h1
`define DIHP_SW_WDATA       4'h2
`define DIHP_SW_STATUS      4'h3
`define DIHP_SW_RDATA       4'h4
`define DIHP_SW_RESET       4'h5
`define DIHP_SW_STALL       4'h6
`define DIHP_ST_BUSY        0
`define DIHP_ST_PROM        1
`define DIHP_ST_RESET       2
`define DIHP_STALL_MAX      16'hffff

`endif

// ---- logic/dihp_pkg.sv ----
// Types shared by both ends of the disk host port
package dihp_pkg;

  // Board end sequencer
  typedef enum logic [3:0] {
    DIHP_D_IDLE  = 4'h1,
    DIHP_D_WAIT  = 4'h2,
    DIHP_D_CTLRD = 4'h4,
    DIHP_D_DONE  = 4'h8
  } dihp_dev_state_t;

  // Processor end sequencer
  typedef enum logic [1:0] {
    DIHP_H_IDLE = 2'h1,
    DIHP_H_BUSY = 2'h2
  } dihp_host_state_t;

  // Bus cycle kinds ordered by software
  typedef enum logic [2:0] {
    DIHP_K_NONE  = 3'h0,
    DIHP_K_IORD  = 3'h1,
    DIHP_K_IOWR  = 3'h2,
    DIHP_K_FETCH = 3'h3,
    DIHP_K_MEMRD = 3'h4,
    DIHP_K_MEMWR = 3'h5
  } dihp_kind_t;

endpackage

// ---- logic/dihp_bus_if.sv ----
// Processor bus between the processor end and the disk interface board
`timescale 1ns/1ps
interface dihp_bus_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        io_rd;
  logic        io_wr;
  logic        mem_fetch;
  logic        mem_rd;
  logic        mem_wr;
  logic        sys_reset;
  logic        ack;
  logic [7:0]  rdata;
  logic        prom_hit;

  modport board (
    input  addr, wdata, io_rd, io_wr, mem_fetch, mem_rd, mem_wr, sys_reset,
    output ack, rdata, prom_hit
  );

  modport cpu (
    output addr, wdata, io_rd, io_wr, mem_fetch, mem_rd, mem_wr, sys_reset,
    input  ack, rdata, prom_hit
  );
endinterface

// ---- logic/dihp_board.sv ----
// Disk interface board: port decode, wait port, write buffer, boot overlay
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "dihp_regs.svh"
module dihp_board
  import dihp_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  dihp_bus_if.board       bus,
  input  wire logic [4:0] dev_addr_sw,
  input  wire logic       boot_en_sw,
  input  wire logic       byte_request,
  input  wire logic       op_complete_irq,
  input  wire logic       index_pulse,
  output logic            ctl_rd,
  output logic [1:0]      ctl_rd_addr,
  input  wire logic [7:0] ctl_rdata,
  output logic            ctl_wr_valid,
  output logic [1:0]      ctl_wr_addr,
  output logic [7:0]      ctl_wr_data,
  input  wire logic       ctl_wr_ready,
  output logic [1:0]      drive_select,
  output logic [7:0]      ext_cmd,
  output logic            head_loaded,
  output logic            boot_active
);

  localparam int W = 10;

  // The shift-down buffer only makes sense with room for at least two words
  if (DEPTH < 2 || DEPTH > 8) begin : g_depth_check
    $error("dihp_board: DEPTH must lie between 2 and 8");
  end

  // Bootstrap image: wait home, read sector 1 into 0000, jump on good status
  localparam logic [7:0] PROM [32] = '{
    8'hdb, 8'hfc, 8'haf, 8'h6f, 8'h67, 8'h3c, 8'hd3, 8'hfa,
    8'h3e, 8'h8c, 8'hd3, 8'hf8, 8'hdb, 8'hfc, 8'hb7, 8'hf2,
    8'h19, 8'h00, 8'hdb, 8'hfb, 8'h77, 8'h23, 8'hc3, 8'h0c,
    8'h00, 8'hdb, 8'hf8, 8'hb7, 8'hca, 8'h7d, 8'h00, 8'h76
  };

  typedef struct packed {
    dihp_dev_state_t             state;
    logic                        ack;
    logic [7:0]                  rdata;
    logic                        prom_hit;
    logic [DEPTH-1:0][W-1:0]     buffer;
    logic [DEPTH-1:0]            vld;
    logic                        ctl_rd;
    logic [1:0]                  ctl_rd_addr;
    logic [7:0]                  ext_cmd;
    logic                        head_loaded;
    logic [1:0]                  revs;
    logic                        boot;
  } dihp_dev_st_t;

  localparam dihp_dev_st_t RESET_ST = '{
    state: DIHP_D_IDLE, ext_cmd: `DIHP_EXT_RESET, default: '0
  };

  dihp_dev_st_t st;
  dihp_dev_st_t next_st;

  // Next state of the whole board
  always_comb begin
    logic       hit;
    logic [2:0] idx;
    logic       pushed;
    logic       full;
    hit    = 1'b0;
    idx    = 3'h0;
    pushed = 1'b0;
    full   = 1'b0;
    next_st        = st;
    next_st.ack    = 1'b0;
    next_st.ctl_rd = 1'b0;

    // Drain the buffer head toward the controller
    if (st.vld[0] && ctl_wr_ready) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (i < DEPTH - 1) begin
          next_st.buffer[i] = st.buffer[i+1];
          next_st.vld[i]    = st.vld[i+1];
        end else begin
          next_st.vld[i] = 1'b0;
        end
      end
    end
    full = next_st.vld[DEPTH-1];

    hit = (bus.addr[`DIHP_DEV_HI:`DIHP_DEV_LO] == dev_addr_sw);
    idx = bus.addr[2:0];

    case (st.state)
      DIHP_D_IDLE: begin
        if (bus.io_rd) begin
          if (!hit) begin
            next_st.rdata = `DIHP_NO_PORT_DATA;
            next_st.ack   = 1'b1;
          end else if (idx == 3'(`DIHP_PORT_WAIT)) begin
            next_st.state = DIHP_D_WAIT;
          end else if (!idx[`DIHP_FAR_IDX]) begin
            // Reads wait for queued writes so the controller sees program order
            if (st.vld == '0) begin
              next_st.ctl_rd      = 1'b1;
              next_st.ctl_rd_addr = idx[1:0];
              next_st.state       = DIHP_D_CTLRD;
            end
          end else begin
            next_st.rdata = `DIHP_UNMAPPED_DATA;
            next_st.ack   = 1'b1;
          end
        end else if (bus.io_wr) begin
          // Only the low three address bits pick the port; the switches own the rest
          if (hit && idx == 3'(`DIHP_PORT_WAIT)) begin
            next_st.ext_cmd = bus.wdata;
            next_st.ack     = 1'b1;
          end else if (hit && !idx[`DIHP_FAR_IDX]) begin
            // A full buffer withholds the answer, stalling the processor
            if (!full) begin
              for (int i = 0; i < DEPTH; i++) begin
                if (!pushed && !next_st.vld[i]) begin
                  next_st.buffer[i] = {idx[1:0], bus.wdata};
                  next_st.vld[i]    = 1'b1;
                  pushed            = 1'b1;
                end
              end
              next_st.ack = 1'b1;
              // Sector commands with the load bit set load the head
              if (idx == 3'(`DIHP_PORT_CMD)
                  && bus.wdata[`DIHP_CMD_TYPE_HI:`DIHP_CMD_TYPE_LO] == `DIHP_CMD_TYPE2
                  && bus.wdata[`DIHP_CMD_HLD_BIT]) begin
                next_st.head_loaded = 1'b1;
                next_st.revs        = 2'h0;
              end
            end
          end else begin
            next_st.ack = 1'b1;
          end
        end else if (bus.mem_fetch) begin
          next_st.ack      = 1'b1;
          next_st.prom_hit = 1'b0;
          if (st.boot && bus.addr < `DIHP_PROM_WORDS) begin
            next_st.rdata    = PROM[bus.addr[`DIHP_PROM_AW-1:0]];
            next_st.prom_hit = 1'b1;
          end else if (st.boot && !bus.sys_reset) begin
            next_st.boot = 1'b0;
          end
        end else if (bus.mem_rd || bus.mem_wr) begin
          // Data cycles are left to main memory, even under the overlay
          next_st.ack      = 1'b1;
          next_st.prom_hit = 1'b0;
        end
      end
      DIHP_D_WAIT: begin
        // Request wins a tie so no data byte is lost
        if (byte_request) begin
          next_st.rdata = `DIHP_WAIT_BY_REQ;
          next_st.ack   = 1'b1;
          next_st.state = DIHP_D_DONE;
        end else if (op_complete_irq) begin
          next_st.rdata = `DIHP_WAIT_BY_IRQ;
          next_st.ack   = 1'b1;
          next_st.state = DIHP_D_DONE;
        end
      end
      DIHP_D_CTLRD: begin
        next_st.rdata = ctl_rdata;
        next_st.ack   = 1'b1;
        next_st.state = DIHP_D_DONE;
      end
      DIHP_D_DONE: begin
        next_st.state = DIHP_D_IDLE;
      end
      default: begin
        next_st.state = DIHP_D_IDLE;
      end
    endcase

    if (next_st.ack && st.state == DIHP_D_IDLE) begin
      next_st.state = DIHP_D_DONE;
    end

    // Overlay armed while reset is held with the boot switch on
    if (bus.sys_reset) begin
      next_st.boot = boot_en_sw;
    end

    // Count revolutions after load; a new load restarts the count
    if (st.head_loaded && index_pulse && next_st.revs == st.revs) begin
      if (st.revs == `DIHP_HEAD_REVS - 2'h1) begin
        next_st.head_loaded = 1'b0;
        next_st.revs        = 2'h0;
      end else begin
        next_st.revs = st.revs + 2'h1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign bus.ack      = st.ack;
  assign bus.rdata    = st.rdata;
  assign bus.prom_hit = st.prom_hit;
  assign ctl_rd       = st.ctl_rd;
  assign ctl_rd_addr  = st.ctl_rd_addr;
  assign ctl_wr_valid = st.vld[0];
  assign ctl_wr_addr  = st.buffer[0][W-1:W-2];
  assign ctl_wr_data  = st.buffer[0][7:0];
  assign drive_select = st.ext_cmd[`DIHP_DRV_HI:`DIHP_DRV_LO];
  assign ext_cmd      = st.ext_cmd;
  assign head_loaded  = st.head_loaded;
  assign boot_active  = st.boot;

endmodule

// ---- logic/dihp_cpu.sv ----
// Processor end: runs bus cycles ordered by software through its own registers
`timescale 1ns/1ps
`include "dihp_regs.svh"
module dihp_cpu
  import dihp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  dihp_bus_if.cpu          bus,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [15:0]      sw_rdata
);

  typedef struct packed {
    dihp_host_state_t state;
    logic [15:0]      addr;
    logic [7:0]       wdata;
    logic             io_rd;
    logic             io_wr;
    logic             mem_fetch;
    logic             mem_rd;
    logic             mem_wr;
    logic             sys_reset;
    logic [7:0]       rdata;
    logic             prom_hit;
    logic [15:0]      stall;
    logic [15:0]      sw_rdata;
  } dihp_cpu_st_t;

  localparam dihp_cpu_st_t RESET_ST = '{state: DIHP_H_IDLE, default: '0};

  dihp_cpu_st_t st;
  dihp_cpu_st_t next_st;

  // Software orders, bus cycle tracking and read-back
  always_comb begin
    dihp_kind_t kind;
    kind    = dihp_kind_t'(sw_wdata[2:0]);
    next_st = st;

    if (sw_wr) begin
      case (sw_addr)
        `DIHP_SW_ADDR:  next_st.addr      = sw_wdata;
        `DIHP_SW_WDATA: next_st.wdata     = sw_wdata[7:0];
        `DIHP_SW_RESET: next_st.sys_reset = sw_wdata[0];
        default: ;
      endcase
    end

    case (st.state)
      DIHP_H_IDLE: begin
        // Orders during a cycle are dropped; software polls busy first
        if (sw_wr && sw_addr == `DIHP_SW_ORDER && kind != DIHP_K_NONE) begin
          next_st.io_rd     = (kind == DIHP_K_IORD);
          next_st.io_wr     = (kind == DIHP_K_IOWR);
          next_st.mem_fetch = (kind == DIHP_K_FETCH);
          next_st.mem_rd    = (kind == DIHP_K_MEMRD);
          next_st.mem_wr    = (kind == DIHP_K_MEMWR);
          next_st.stall     = 16'h0000;
          if (kind inside {DIHP_K_IORD, DIHP_K_IOWR, DIHP_K_FETCH,
                           DIHP_K_MEMRD, DIHP_K_MEMWR}) begin
            next_st.state = DIHP_H_BUSY;
          end
        end
      end
      DIHP_H_BUSY: begin
        if (bus.ack) begin
          next_st.io_rd     = 1'b0;
          next_st.io_wr     = 1'b0;
          next_st.mem_fetch = 1'b0;
          next_st.mem_rd    = 1'b0;
          next_st.mem_wr    = 1'b0;
          next_st.rdata     = bus.rdata;
          next_st.prom_hit  = bus.prom_hit;
          next_st.state     = DIHP_H_IDLE;
        end else if (st.stall != `DIHP_STALL_MAX) begin
          next_st.stall = st.stall + 16'h0001;
        end
      end
      default: begin
        next_st.state = DIHP_H_IDLE;
      end
    endcase

    next_st.sw_rdata = 16'h0000;
    if (sw_rd) begin
      case (sw_addr)
        `DIHP_SW_ADDR:   next_st.sw_rdata = st.addr;
        `DIHP_SW_WDATA:  next_st.sw_rdata = {8'h00, st.wdata};
        `DIHP_SW_STATUS: begin
          next_st.sw_rdata[`DIHP_ST_BUSY]  = (st.state == DIHP_H_BUSY);
          next_st.sw_rdata[`DIHP_ST_PROM]  = st.prom_hit;
          next_st.sw_rdata[`DIHP_ST_RESET] = st.sys_reset;
        end
        `DIHP_SW_RDATA:  next_st.sw_rdata = {8'h00, st.rdata};
        `DIHP_SW_RESET:  next_st.sw_rdata = {15'h0000, st.sys_reset};
        `DIHP_SW_STALL:  next_st.sw_rdata = st.stall;
        default:         next_st.sw_rdata = 16'h0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // Bus and software outputs straight from the state register
  assign bus.addr      = st.addr;
  assign bus.wdata     = st.wdata;
  assign bus.io_rd     = st.io_rd;
  assign bus.io_wr     = st.io_wr;
  assign bus.mem_fetch = st.mem_fetch;
  assign bus.mem_rd    = st.mem_rd;
  assign bus.mem_wr    = st.mem_wr;
  assign bus.sys_reset = st.sys_reset;
  assign sw_rdata      = st.sw_rdata;

endmodule

// ---- test/dihp_bus_monitor.sv ----
// Bus checker for the link between processor end and disk board
`timescale 1ns/1ps
module dihp_bus_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic        mem_fetch,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        sys_reset,
  input wire logic        ack,
  input wire logic [7:0]  rdata,
  input wire logic        prom_hit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Any strobe at all; an ack with no request behind it is a stray
  wire logic any_req = io_rd | io_wr | mem_fetch | mem_rd | mem_wr;

  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("ack held over one cycle");
  a_ack_has_cause: assert property (ack |-> $past(any_req))
    else $error("ack without a request");
  a_wait_code: assert property (ack && io_rd && addr[7:0] == 8'hfc |-> rdata[6:0] == 7'h00)
    else $error("wait answer not 80 or 00");
  a_wait_bounded: assert property ($rose(io_rd) && addr[7:0] == 8'hfc |-> ##[1:300] ack)
    else $error("wait read never released");
  a_foreign_read: assert property ($rose(io_rd) && addr[7:3] == 5'h10 |=> ack && rdata == 8'hff)
    else $error("foreign port read not ff");
  a_io_write_done: assert property ($rose(io_wr) |-> ##[1:60] ack)
    else $error("port write never acked");
  a_mem_to_main: assert property ($rose(mem_rd | mem_wr) |=> ack && !prom_hit)
    else $error("data cycle served by prom");
  a_fetch_high: assert property ($rose(mem_fetch) && addr >= 16'h0020 |=> ack && !prom_hit)
    else $error("fetch above prom from prom");

  // Main scenarios reached
  c_wait_req: cover property (ack && io_rd && rdata == 8'h80);
  c_wait_irq: cover property (ack && io_rd && addr[7:0] == 8'hfc && rdata == 8'h00);
  c_prom: cover property (ack && prom_hit);
endmodule

// ---- test/tb.sv ----
// Self-checking bench: processor end and disk board joined by the bus
`timescale 1ns/1ps
`include "dihp_regs.svh"
module tb;
  import dihp_pkg::*;
  logic        core_clk;
  logic        rst;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [15:0] sw_rdata;
  logic [4:0]  dev_addr_sw;
  logic        boot_en_sw;
  logic        byte_request;
  logic        op_complete_irq;
  logic        index_pulse;
  logic        ctl_rd;
  logic [1:0]  ctl_rd_addr;
  logic [7:0]  ctl_rdata;
  logic        ctl_wr_valid;
  logic [1:0]  ctl_wr_addr;
  logic [7:0]  ctl_wr_data;
  logic        ctl_wr_ready;
  logic [1:0]  drive_select;
  logic [7:0]  ext_cmd;
  logic        head_loaded;
  logic        boot_active;
  logic [7:0]  creg [4];
  logic [9:0]  wlog [$];
  logic [15:0] rd;
  logic [7:0]  cmds [3] = '{8'h8c, 8'hac, 8'h88};
  logic        hl_exp [3] = '{1'b1, 1'b1, 1'b0};
  logic [1:0]  ev [3] = '{2'b10, 2'b01, 2'b11};
  int          n_errors;
  int          checks;

  dihp_bus_if bus ();
  dihp_board #(.DEPTH(2)) dihp_board_inst (.core_clk(core_clk), .rst(rst), .bus(bus),
    .dev_addr_sw(dev_addr_sw), .boot_en_sw(boot_en_sw), .byte_request(byte_request),
    .op_complete_irq(op_complete_irq), .index_pulse(index_pulse), .ctl_rd(ctl_rd),
    .ctl_rd_addr(ctl_rd_addr), .ctl_rdata(ctl_rdata), .ctl_wr_valid(ctl_wr_valid),
    .ctl_wr_addr(ctl_wr_addr), .ctl_wr_data(ctl_wr_data), .ctl_wr_ready(ctl_wr_ready),
    .drive_select(drive_select), .ext_cmd(ext_cmd), .head_loaded(head_loaded),
    .boot_active(boot_active));
  dihp_cpu dihp_cpu_inst (.core_clk(core_clk), .rst(rst), .bus(bus), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  dihp_bus_monitor dihp_bus_monitor_inst (.core_clk(core_clk), .rst(rst), .addr(bus.addr),
    .wdata(bus.wdata), .io_rd(bus.io_rd), .io_wr(bus.io_wr), .mem_fetch(bus.mem_fetch),
    .mem_rd(bus.mem_rd), .mem_wr(bus.mem_wr), .sys_reset(bus.sys_reset), .ack(bus.ack),
    .rdata(bus.rdata), .prom_hit(bus.prom_hit));

  // Clock at 20 MHz
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Controller stand-in: register file plus a log of words popped from the buffer
  assign ctl_rdata = creg[ctl_rd_addr];
  always @(posedge core_clk) begin
    if (ctl_wr_valid && ctl_wr_ready) begin
      creg[ctl_wr_addr] <= ctl_wr_data;
      wlog.push_back({ctl_wr_addr, ctl_wr_data});
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    // Taken at the closing edge, before the register moves on
    @(posedge core_clk);
    d = sw_rdata;
  endtask

  // One bus cycle ordered by software, busy polled under a bound
  task automatic bus_op(input dihp_kind_t k, input logic [15:0] a, input logic [7:0] w,
                        output logic [15:0] d);
    logic [15:0] st;
    sw_write(`DIHP_SW_ADDR, a);
    sw_write(`DIHP_SW_WDATA, {8'h00, w});
    sw_write(`DIHP_SW_ORDER, {13'h0000, k});
    for (int i = 0; i < 400; i++) begin
      sw_read(`DIHP_SW_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    chk("busy", 16'h0000, {15'h0000, st[0]});
    sw_read(`DIHP_SW_RDATA, d);
  endtask

  task automatic stop_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("BAD watchdog expected finish seen hang");
    stop_test();
  end

  initial begin
    {rst, sw_wr, sw_rd, boot_en_sw, byte_request, op_complete_irq, index_pulse} = 7'h40;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    dev_addr_sw = 5'h1f;
    ctl_wr_ready = 1'b1;
    foreach (creg[i]) creg[i] = 8'h00;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Sector and command reach the controller in order; sector reads back
    bus_op(DIHP_K_IOWR, 16'h00fa, 8'h01, rd);
    bus_op(DIHP_K_IOWR, 16'h00f8, 8'h8c, rd);
    chk("log sector", 16'h0201, {6'h00, wlog[0]});
    chk("log command", 16'h008c, {6'h00, wlog[1]});
    bus_op(DIHP_K_IORD, 16'h00fa, 8'h00, rd);
    chk("sector read", 16'h0001, rd);
    // Head loads on sector commands with the load bit, drops after two revolutions
    for (int i = 0; i < 3; i++) begin
      bus_op(DIHP_K_IOWR, 16'h00f8, cmds[i], rd);
      chk("head load", {15'h0000, hl_exp[i]}, {15'h0000, head_loaded});
      for (int p = 0; p < 2; p++) begin
        @(posedge core_clk) index_pulse <= 1'b1;
        @(posedge core_clk) index_pulse <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("head idle", {15'h0000, hl_exp[i] & (p == 0)}, {15'h0000, head_loaded});
      end
    end
    // Wait port holds until an event, then reports which one, request winning a tie
    for (int i = 0; i < 3; i++) begin
      fork
        bus_op(DIHP_K_IORD, 16'h00fc, 8'h00, rd);
        begin
          repeat (20) @(posedge core_clk);
          chk("wait held", 16'h0001, {15'h0000, bus.io_rd});
          byte_request    <= ev[i][1];
          op_complete_irq <= ev[i][0];
        end
      join
      chk("wait answer", {8'h00, ev[i][1], 7'h00}, rd);
      byte_request    <= 1'b0;
      op_complete_irq <= 1'b0;
    end
    // Event raised 14 edges after the cycle started: released on the next edge
    sw_read(`DIHP_SW_STALL, rd);
    chk("stall count", 16'h000f, rd);
    // Status after completion comes from the controller's command/status slot
    bus_op(DIHP_K_IORD, 16'h00f8, 8'h00, rd);
    chk("status after irq", 16'h0088, rd);
    // Address switches choose the high bits; foreign and unmapped ports
    bus_op(DIHP_K_IORD, 16'h0080, 8'h00, rd);
    chk("foreign read", 16'h00ff, rd);
    bus_op(DIHP_K_IORD, 16'h00fd, 8'h00, rd);
    chk("unmapped port", 16'h0000, rd);
    dev_addr_sw <= 5'h1e;
    bus_op(DIHP_K_IORD, 16'h00f2, 8'h00, rd);
    chk("moved sector", 16'h0001, rd);
    bus_op(DIHP_K_IORD, 16'h00fa, 8'h00, rd);
    chk("old address", 16'h00ff, rd);
    dev_addr_sw <= 5'h1f;
    // Write to the wait address loads the drive latch, not the controller
    wlog.delete();
    bus_op(DIHP_K_IOWR, 16'h00fc, 8'h32, rd);
    chk("drive select", 16'h0003, {14'h0000, drive_select});
    chk("ext latch", 16'h0032, {8'h00, ext_cmd});
    chk("ext not passed", 16'h0000, 16'(wlog.size()));
    // Controller stalls: two bytes fill the buffer, the third waits; none lost
    ctl_wr_ready <= 1'b0;
    bus_op(DIHP_K_IOWR, 16'h00fb, 8'h11, rd);
    bus_op(DIHP_K_IOWR, 16'h00fb, 8'h22, rd);
    fork
      bus_op(DIHP_K_IOWR, 16'h00fb, 8'h33, rd);
      begin
        repeat (30) @(posedge core_clk);
        chk("third held", 16'h0001, {15'h0000, bus.io_wr});
        ctl_wr_ready <= 1'b1;
      end
    join
    for (int i = 0; i < 3; i++)
      chk("buffer order", {8'h03, 8'(8'h11 * (i + 1))}, {6'h00, wlog[i]});
    // Boot overlay: low fetches from the PROM, stores to main memory
    boot_en_sw <= 1'b1;
    sw_write(`DIHP_SW_RESET, 16'h0001);
    sw_write(`DIHP_SW_RESET, 16'h0000);
    bus_op(DIHP_K_FETCH, 16'h0000, 8'h00, rd);
    chk("boot byte 0", 16'h00db, rd);
    chk("boot active", 16'h0001, {15'h0000, boot_active});
    sw_read(`DIHP_SW_STATUS, rd);
    chk("fetch from prom", 16'h0001, {15'h0000, rd[1]});
    bus_op(DIHP_K_FETCH, 16'h0001, 8'h00, rd);
    chk("boot byte 1", 16'h00fc, rd);
    bus_op(DIHP_K_MEMWR, 16'h0000, 8'h5a, rd);
    sw_read(`DIHP_SW_STATUS, rd);
    chk("store to memory", 16'h0000, {15'h0000, rd[1]});
    bus_op(DIHP_K_FETCH, 16'h0020, 8'h00, rd);
    chk("overlay off", 16'h0000, {15'h0000, boot_active});
    bus_op(DIHP_K_FETCH, 16'h0100, 8'h00, rd);
    sw_read(`DIHP_SW_STATUS, rd);
    chk("high boot from memory", 16'h0000, {15'h0000, rd[1]});
    stop_test();
  end
endmodule
